// ==== logic/srp_top.sv ====
// module: host-facing serial cable replacement port with ahb-lite register slave
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module srp_top import srp_pkg::*; (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  // host serial pins
  output logic             uart_txd,
  input  wire logic        uart_rxd,
  output logic             uart_rts_n,
  input  wire logic        uart_cts_n,
  // connectivity pins
  input  wire logic        disconnect_request_line,
  output logic             link_up_indicator_line,
  // handshake lines 4..7 (ri, dtr, dcd, dsr)
  input  wire logic [3:0]  general_io_line_in,
  output logic [3:0]       general_io_line_out,
  output logic [3:0]       general_io_line_oe,
  // radio stack side
  output logic             radio_page,
  output logic             radio_accept,
  output logic             radio_close,
  input  wire logic        radio_incoming,
  input  wire logic        radio_up,
  output logic [7:0]       link_tx_data,
  output logic             link_tx_valid,
  input  wire logic        link_tx_ready,
  input  wire logic [7:0]  link_rx_data,
  input  wire logic        link_rx_valid,
  output logic             link_rx_ready,
  output logic [3:0]       link_hs_tx,
  input  wire logic [3:0]  link_hs_rx,
  // persistent store and restart
  output logic             nv_store,
  output logic [2:0]       nv_data,
  output logic             module_restart
);
  // *************************************************************
  // pin synchronisers
  // *************************************************************
  logic [7:0]            meta_r;     // first stage, read only by sync_r
  logic [7:0]            sync_r;     // second stage
  logic                  rxd_s;      // synchronised serial input
  logic                  cts_s;      // synchronised clear to send (low active)
  logic                  disc_s;     // synchronised disconnect request
  logic [3:0]            gio_s;      // synchronised handshake inputs

  // two flops on every asynchronous pin; idle levels as reset values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 8'h03;
      sync_r <= 8'h03;
    end else begin
      // bit 3 is a spare stage so the handshake lines land on bits 7..4
      meta_r <= {general_io_line_in, 1'b0, disconnect_request_line, uart_cts_n, uart_rxd};
      sync_r <= meta_r;
    end
  end
  assign rxd_s  = sync_r[0];
  assign cts_s  = sync_r[1];
  assign disc_s = sync_r[2];
  assign gio_s  = sync_r[7:4];

  // *************************************************************
  // ahb-lite slave
  // *************************************************************
  logic                  dp_valid_r; // data phase pending
  logic                  dp_write_r; // data phase is a write
  logic [7:0]            dp_addr_r;  // latched word offset
  logic [2:0]            ctrl_r;     // mode, role, accept enable
  logic [4:0]            irq_st_r;   // sticky events
  logic [4:0]            irq_msk_r;  // interrupt enables
  logic [4:0]            irq_set;    // events of this cycle
  logic                  ap_take;    // address phase accepted
  logic                  wr_ctrl;    // write strobes
  logic                  wr_cmd;
  logic                  wr_tx;
  logic                  wr_msk;
  logic                  rd_rx;      // read strobes
  logic                  rd_ist;
  logic                  in_hcm;     // command mode active
  logic                  enter_req;  // command pulses
  logic                  leave_req;
  logic                  reboot_req;

  assign ap_take    = hsel && htrans[1] && hready;
  assign wr_ctrl    = dp_valid_r && dp_write_r && (dp_addr_r == OFS_CTRL);
  assign wr_cmd     = dp_valid_r && dp_write_r && (dp_addr_r == OFS_CMD);
  assign wr_tx      = dp_valid_r && dp_write_r && (dp_addr_r == OFS_TXDATA);
  assign wr_msk     = dp_valid_r && dp_write_r && (dp_addr_r == OFS_IRQ_MSK);
  assign rd_rx      = dp_valid_r && !dp_write_r && (dp_addr_r == OFS_RXDATA);
  assign rd_ist     = dp_valid_r && !dp_write_r && (dp_addr_r == OFS_IRQ_ST);
  assign enter_req  = wr_cmd && hwdata[CMD_ENTER];
  assign leave_req  = wr_cmd && hwdata[CMD_LEAVE];
  assign reboot_req = wr_cmd && hwdata[CMD_REBOOT] && in_hcm;
  assign hreadyout  = 1'b1;  // zero wait states, every access completes at once
  assign hresp      = 1'b0;  // always okay
  assign irq        = |(irq_st_r & irq_msk_r);

  // capture the address phase; only the word offset matters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 8'h00;
    end else if (hready) begin
      dp_valid_r <= ap_take;
      dp_write_r <= hwrite;
      dp_addr_r  <= {haddr[7:2], 2'b00};
    end
  end

  // ctrl is only changed in command mode, and every ctrl change is stored; the irq mask is written in any state, unstored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= CTRL_RESET;
      irq_msk_r <= IRQ_MSK_RESET;
      nv_store  <= 1'b0;
      nv_data   <= CTRL_RESET;
    end else begin
      nv_store <= wr_ctrl && in_hcm;
      if (wr_ctrl && in_hcm) begin
        ctrl_r  <= hwdata[2:0];
        nv_data <= hwdata[2:0];
      end
      if (wr_msk) begin
        irq_msk_r <= hwdata[4:0];
      end
    end
  end

  // read clears the sticky bits, but an event in the same cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_r <= 5'h00;
    end else begin
      irq_st_r <= (rd_ist ? 5'h00 : irq_st_r) | irq_set;
    end
  end

  // *************************************************************
  // connection state machine
  // *************************************************************
  srp_state_type         state_r;    // current connection state
  srp_state_type         state_nxt;
  srp_state_type         seek_st;    // where to look for a link
  logic                  disc_d_r;   // delayed disconnect for edge

  assign seek_st = ctrl_r[CTRL_CONNECTING] ? ST_PAGE : ST_LISTEN;
  assign in_hcm  = (state_r == ST_HCM);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (enter_req) begin
          state_nxt = ST_HCM;
        end else if (!disc_s) begin
          state_nxt = seek_st;
        end
      end
      ST_PAGE, ST_LISTEN: begin
        if (disc_s) begin
          state_nxt = ST_IDLE;
        end else if (enter_req) begin
          state_nxt = ST_HCM;
        end else if (radio_up) begin
          state_nxt = ST_UP;
        end
      end
      ST_UP: begin
        // command requests are ignored while linked
        if (disc_s) begin
          state_nxt = ST_IDLE;
        end else if (!radio_up) begin
          state_nxt = seek_st;
        end
      end
      ST_HCM: begin
        if (leave_req || reboot_req) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r        <= ST_IDLE;
      disc_d_r       <= 1'b0;
      module_restart <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      disc_d_r       <= disc_s;
      module_restart <= reboot_req;
    end
  end

  // paging is held so the radio retries until a link forms
  assign radio_page   = (state_r == ST_PAGE) && !disc_s;
  assign radio_accept = (state_r == ST_LISTEN) && !disc_s && radio_incoming
                        && ctrl_r[CTRL_ACCEPT];
  assign radio_close  = disc_s;
  assign link_up_indicator_line = (state_r == ST_UP);

  // *************************************************************
  // receive side: serial pin to holding byte
  // *************************************************************
  logic                  rx_busy_r;  // frame in progress
  logic [10:0]           rx_cnt_r;   // cycles to next sample
  logic [3:0]            rx_bit_r;   // sample index in frame
  logic [7:0]            rx_sh_r;    // shift register
  logic                  rx_full_r;  // holding byte valid
  logic [7:0]            rx_hold_r;  // holding byte
  logic                  rx_done;    // good stop bit sampled
  logic                  rx_pop;     // holding byte consumed
  logic                  rx_tick;    // sample instant

  assign rx_tick = rx_busy_r && (rx_cnt_r == 11'h000);
  assign rx_done = rx_tick && (rx_bit_r == FRAME_BITS - 4'h1) && rxd_s;
  // linked: bytes go to the radio only, never to the command path
  assign rx_pop  = (link_tx_valid && link_tx_ready) || (rd_rx && in_hcm);
  assign link_tx_valid = rx_full_r && (state_r == ST_UP);
  assign link_tx_data  = rx_hold_r;
  assign uart_rts_n    = rx_full_r;

  // sample mid-bit; a false start (high at mid start bit) is abandoned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_busy_r <= 1'b0;
      rx_cnt_r  <= 11'h000;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
    end else if (!rx_busy_r) begin
      rx_busy_r <= !rxd_s;
      rx_cnt_r  <= HALF_CYC;
      rx_bit_r  <= 4'h0;
    end else if (rx_tick) begin
      rx_cnt_r <= BIT_CYC - 11'h001;
      rx_bit_r <= rx_bit_r + 4'h1;
      if ((rx_bit_r == 4'h0 && rxd_s) || rx_bit_r == FRAME_BITS - 4'h1) begin
        rx_busy_r <= 1'b0;
      end
      if (rx_bit_r != 4'h0 && rx_bit_r != FRAME_BITS - 4'h1) begin
        rx_sh_r <= {rxd_s, rx_sh_r[7:1]};  // lsb first
      end
    end else begin
      rx_cnt_r <= rx_cnt_r - 11'h001;
    end
  end

  // a byte that finds the holding register full is dropped and flagged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_full_r <= 1'b0;
      rx_hold_r <= 8'h00;
    end else if (rx_done && (!rx_full_r || rx_pop)) begin
      rx_full_r <= 1'b1;
      rx_hold_r <= rx_sh_r;
    end else if (rx_pop) begin
      rx_full_r <= 1'b0;
    end
  end

  // *************************************************************
  // transmit side: remote or command reply to serial pin
  // *************************************************************
  logic                  tx_busy_r;  // frame in progress
  logic [10:0]           tx_cnt_r;   // cycles left in bit
  logic [3:0]            tx_bit_r;   // bits left
  logic [9:0]            tx_sh_r;    // frame shifter
  logic                  tx_load;    // start a frame
  logic [7:0]            tx_byte;    // byte to frame

  // host holds off remote bytes with cts, command replies ignore it; a started frame always completes
  assign link_rx_ready = !tx_busy_r && !cts_s && (state_r == ST_UP);
  assign tx_load = (link_rx_valid && link_rx_ready) || (wr_tx && in_hcm && !tx_busy_r);
  assign tx_byte = (state_r == ST_UP) ? link_rx_data : hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_busy_r <= 1'b0;
      tx_cnt_r  <= 11'h000;
      tx_bit_r  <= 4'h0;
      tx_sh_r   <= 10'h3FF;
      uart_txd  <= 1'b1;
    end else if (tx_load) begin
      tx_busy_r <= 1'b1;
      tx_cnt_r  <= BIT_CYC - 11'h001;
      tx_bit_r  <= FRAME_BITS - 4'h1;
      tx_sh_r   <= {1'b1, tx_byte, 1'b0};
      uart_txd  <= 1'b0;
    end else if (tx_busy_r && tx_cnt_r == 11'h000) begin
      tx_cnt_r  <= BIT_CYC - 11'h001;
      tx_bit_r  <= tx_bit_r - 4'h1;
      tx_busy_r <= (tx_bit_r != 4'h0);
      tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
      uart_txd  <= (tx_bit_r == 4'h0) ? 1'b1 : tx_sh_r[1];
    end else if (tx_busy_r) begin
      tx_cnt_r <= tx_cnt_r - 11'h001;
    end
  end

  // *************************************************************
  // handshake line emulation
  // *************************************************************
  logic [3:0]            hs_out_r;   // levels driven to the host
  logic [3:0]            hs_dir;     // 1: line is an output

  // dte drives only dtr; dce drives the other three
  generate
    for (genvar i = 0; i < 4; i++) begin : g_hs
      assign hs_dir[i] = ctrl_r[CTRL_DCE] ? (i != HS_DTR) : (i == HS_DTR);
      assign link_hs_tx[i] = !hs_dir[i] && gio_s[i];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          hs_out_r[i] <= 1'b0;
        end else begin
          hs_out_r[i] <= hs_dir[i] && link_hs_rx[i] && (state_r == ST_UP);
        end
      end
    end
  endgenerate
  assign general_io_line_out = hs_out_r;
  assign general_io_line_oe  = hs_dir;

  // *************************************************************
  // events and read data
  // *************************************************************
  assign irq_set[IRQ_UP]      = (state_r != ST_UP) && (state_nxt == ST_UP);
  assign irq_set[IRQ_DOWN]    = (state_r == ST_UP) && (state_nxt != ST_UP);
  assign irq_set[IRQ_RXCMD]   = rx_done && in_hcm;
  assign irq_set[IRQ_DISC]    = disc_s && !disc_d_r;
  assign irq_set[IRQ_OVERRUN] = rx_done && rx_full_r && !rx_pop;

  always_comb begin
    hrdata = 32'h0000_0000;  // unmapped and write-only offsets read zero
    if (dp_valid_r && !dp_write_r) begin
      unique case (dp_addr_r)
        OFS_CTRL:    hrdata = {29'h0, ctrl_r};
        OFS_STATUS:  hrdata = {28'h0, tx_busy_r, rx_full_r, in_hcm, link_up_indicator_line};
        OFS_RXDATA:  hrdata = {24'h0, rx_hold_r};
        OFS_IRQ_ST:  hrdata = {27'h0, irq_st_r};
        OFS_IRQ_MSK: hrdata = {27'h0, irq_msk_r};
        default:     hrdata = 32'h0000_0000;
      endcase
    end
  end

  // *************************************************************
  // assertions
  // *************************************************************
  property p_rts_full;
    @(posedge hclk) disable iff (!hresetn)
    (rx_done && !rx_full_r) |=> uart_rts_n;
  endproperty
  a_rts_full: assert property (p_rts_full) else $error("rts not raised on full");

  property p_close;
    @(posedge hclk) disable iff (!hresetn)
    disc_s |-> radio_close ##1 !link_up_indicator_line;
  endproperty
  a_close: assert property (p_close) else $error("link kept on disconnect");

  property p_no_new;
    @(posedge hclk) disable iff (!hresetn)
    disc_s |-> !radio_page && !radio_accept;
  endproperty
  a_no_new: assert property (p_no_new) else $error("connect attempt while blocked");

  property p_up_ind;
    @(posedge hclk) disable iff (!hresetn)
    ((state_r == ST_PAGE || state_r == ST_LISTEN) && radio_up && !disc_s && !enter_req)
      |=> link_up_indicator_line;
  endproperty
  a_up_ind: assert property (p_up_ind) else $error("indicator late");

  property p_hcm_down;
    @(posedge hclk) disable iff (!hresetn)
    in_hcm |-> !link_up_indicator_line && !link_tx_valid;
  endproperty
  a_hcm_down: assert property (p_hcm_down) else $error("command mode while linked");

  property p_fwd;
    @(posedge hclk) disable iff (!hresetn)
    (link_up_indicator_line && rx_full_r) |-> link_tx_valid && (link_tx_data == rx_hold_r);
  endproperty
  a_fwd: assert property (p_fwd) else $error("byte not forwarded");

  property p_nv;
    @(posedge hclk) disable iff (!hresetn)
    (wr_ctrl && in_hcm) |=> nv_store && (nv_data == ctrl_r);
  endproperty
  a_nv: assert property (p_nv) else $error("setting not stored");

  property p_reboot;
    @(posedge hclk) disable iff (!hresetn)
    module_restart |-> $past(in_hcm) && !in_hcm;
  endproperty
  a_reboot: assert property (p_reboot) else $error("restart outside command mode");

  property p_baud;
    @(posedge hclk) disable iff (!hresetn)
    tx_load |=> (tx_cnt_r == BIT_CYC - 11'h001) && !uart_txd;
  endproperty
  a_baud: assert property (p_baud) else $error("bad start bit timing");

  property p_dte_dir;
    @(posedge hclk) disable iff (!hresetn)
    !ctrl_r[CTRL_DCE] |-> (general_io_line_oe == 4'h2);
  endproperty
  a_dte_dir: assert property (p_dte_dir) else $error("dte direction wrong");

  c_link_up:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(link_up_indicator_line));
  c_fwd_byte: cover property (@(posedge hclk) disable iff (!hresetn) link_tx_valid && link_tx_ready);
  c_reboot:   cover property (@(posedge hclk) disable iff (!hresetn) module_restart);
  c_page:     cover property (@(posedge hclk) disable iff (!hresetn) radio_page);
endmodule

// ==== logic/srp_pkg.sv ====
// package: constants, register map and state types of the serial replacement port
//
// Behaviour
// - drive txd and rts, sample rxd and cts
// - disconnect line high closes the radio link
// - disconnect line high blocks any new connection
// - link indicator low unless a connection exists
// - lines 4..7 are RI DTR DCD DSR, role-directed
// - handshake levels mirrored to remote independently
// - connected: serial bytes pass unchanged both ways
// - defaults give transparent transfer with no command
// - command mode only while no connection exists
// - serial framing fixed 38400 8N1 with flow control
// - every configuration change goes to nonvolatile store
// - connecting mode pages remote until connected
// - endpoint mode accepts only when acceptance allowed
// - one data channel, full duplex, once connected
// - single point-to-point link, master or slave
// - reboot command in command mode restarts module
package srp_pkg;
  // *************************************************************
  // serial timing
  // *************************************************************
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned BAUD_BPS    = 38400;
  localparam logic [10:0] BIT_CYC     = 11'((CLK_HZ + BAUD_BPS / 2) / BAUD_BPS);
  localparam logic [10:0] HALF_CYC    = 11'(((CLK_HZ + BAUD_BPS / 2) / BAUD_BPS) / 2);
  localparam logic [3:0]  FRAME_BITS  = 4'hA;  // start + 8 data + stop
  // *************************************************************
  // register map (byte addresses)
  // *************************************************************
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_CMD     = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_RXDATA  = 8'h0C;
  localparam logic [7:0]  OFS_TXDATA  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_ST  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_MSK = 8'h18;
  // ctrl fields
  localparam int unsigned CTRL_CONNECTING = 0;
  localparam int unsigned CTRL_DCE        = 1;
  localparam int unsigned CTRL_ACCEPT     = 2;
  localparam logic [2:0]  CTRL_RESET      = 3'h4;  // endpoint, dte, accept on
  // cmd fields (write pulses)
  localparam int unsigned CMD_ENTER  = 0;
  localparam int unsigned CMD_LEAVE  = 1;
  localparam int unsigned CMD_REBOOT = 2;
  // irq fields
  localparam int unsigned IRQ_UP      = 0;
  localparam int unsigned IRQ_DOWN    = 1;
  localparam int unsigned IRQ_RXCMD   = 2;
  localparam int unsigned IRQ_DISC    = 3;
  localparam int unsigned IRQ_OVERRUN = 4;
  localparam int unsigned IRQ_W       = 5;
  localparam logic [4:0]  IRQ_MSK_RESET = 5'h00;
  // handshake line index of the only dte output (dtr)
  localparam int unsigned HS_DTR = 1;
  // *************************************************************
  // connection states
  // *************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_PAGE, ST_LISTEN, ST_UP, ST_HCM} srp_state_type;
endpackage

// ==== bench/srp_radio_model.sv ====
// radio stack stand-in on the far side of the link ports
`timescale 1ns/1ps
module srp_radio_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       offer,
  input  wire logic       send,
  input  wire logic [7:0] sbyte,
  input  wire logic       radio_accept,
  input  wire logic       radio_close,
  input  wire logic [7:0] link_tx_data,
  input  wire logic       link_tx_valid,
  input  wire logic       link_rx_ready,
  output logic            radio_incoming,
  output logic            radio_up,
  output logic            link_tx_ready,
  output logic [7:0]      link_rx_data,
  output logic            link_rx_valid,
  output logic [7:0]      got
);
  // ready toggles so an outgoing byte waits at most one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      radio_incoming <= 1'b0;
      radio_up <= 1'b0;
      link_tx_ready <= 1'b0;
      link_rx_data <= 8'h00;
      link_rx_valid <= 1'b0;
      got <= 8'h00;
    end else begin
      radio_incoming <= offer & ~radio_incoming;
      link_tx_ready <= ~link_tx_ready;
      if (radio_incoming & radio_accept)
        radio_up <= 1'b1;
      if (radio_close)
        radio_up <= 1'b0;
      if (link_tx_valid & link_tx_ready)
        got <= link_tx_data;
      // idle data wanders so a stale value never looks valid
      if (link_rx_valid) begin
        if (link_rx_ready)
          link_rx_valid <= 1'b0;
      end else if (send) begin
        link_rx_valid <= 1'b1;
        link_rx_data <= sbyte;
      end else
        link_rx_data <= ~link_rx_data;
    end
  end
endmodule

// ==== bench/serial_cable_replacement_port_tb_top.sv ====
// self-checking bench for the serial replacement port
`timescale 1ns/1ps
module serial_cable_replacement_port_tb_top import srp_pkg::*; ;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, uart_txd, uart_rxd;
  logic        uart_rts_n, uart_cts_n, disconnect_request_line, link_up_indicator_line;
  logic        radio_page, radio_accept, radio_close, radio_incoming, radio_up, link_tx_valid;
  logic        link_tx_ready, link_rx_valid, link_rx_ready, nv_store, module_restart;
  logic        offer, send, acc_seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, nv_data;
  logic [3:0]  general_io_line_in, general_io_line_out, general_io_line_oe;
  logic [3:0]  link_hs_tx, link_hs_rx, host_lv;
  logic [7:0]  link_tx_data, link_rx_data, sbyte, got, b, rxv;
  int          errors, tests_run;
  // the one slave's ready is the bus ready; pin level merges both drivers
  assign hready = hreadyout;
  assign general_io_line_in = (general_io_line_oe & general_io_line_out) | (~general_io_line_oe & host_lv);
  srp_top i_srp_top (.*);
  srp_radio_model i_srp_radio_model (.*);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  function automatic logic [3:0] drv_mask(input logic dce);
    return dce ? 4'hD : 4'h2;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait, seen at the falling edge
  task automatic poll(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    @(negedge hclk);
    while (s !== v) begin
      if (++n > lim) begin
        errors++;
        $display("BAD %0t wait ran out", $time);
        final_report();
      end
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic bwait();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      if (++n > 50) begin
        errors++;
        $display("BAD %0t bus wait ran out", $time);
        final_report();
      end
    end while (hready !== 1'b1);
  endtask
  // address phase held until hready, then data phase; read data taken at its edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    bwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    bwait();
    rd = hrdata;
  endtask
  task automatic ser_tx(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uart_rxd <= f[i];
      repeat (BIT_CYC) @(posedge hclk);
    end
  endtask
  task automatic ser_rx(output logic [7:0] v);
    poll(uart_txd, 1'b0, 8000);
    repeat (HALF_CYC) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge hclk);
      v[i] = uart_txd;
    end
    repeat (BIT_CYC) @(posedge hclk);
    chk(uart_txd, 1'b1, "stop bit");
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, offer, send, sbyte, acc_seen} = '0;
    {host_lv, link_hs_rx, uart_cts_n, disconnect_request_line} = '0;
    hsize = 3'h2;
    uart_rxd = 1'b1;
    void'($urandom(32'hB97F));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk(link_up_indicator_line, 1'b0, "link idle");
    chk(uart_rts_n, 1'b0, "rts idle");
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {29'h0, CTRL_RESET}, "ctrl reset");
    ahb(1'b1, OFS_IRQ_MSK, 32'h1);
    offer <= 1'b1;
    poll(link_up_indicator_line, 1'b1, 40);
    offer <= 1'b0;
    chk(irq, 1'b1, "irq up");
    ahb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(rd[0], 1'b1, "irq status");
    poll(irq, 1'b0, 4);
    ahb(1'b1, OFS_CMD, 32'h1);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[1], 1'b0, "no cmd mode while up");
    host_lv <= 4'($urandom);
    link_hs_rx <= 4'($urandom);
    @(posedge hclk);
    for (int n = 0; n < 9; n++) @(posedge hclk);
    chk(general_io_line_out, link_hs_rx & drv_mask(1'b0), "mirror out");
    chk(link_hs_tx, host_lv & ~drv_mask(1'b0), "mirror in");
    chk(general_io_line_oe, drv_mask(1'b0), "dte oe");
    // both directions of the data channel, random bytes
    repeat (2) begin
      b = 8'($urandom);
      ser_tx(b);
      for (int n = 0; n < 100 && got !== b; n++) @(posedge hclk);
      chk(got, b, "host to remote");
      b = 8'($urandom);
      sbyte <= b;
      send <= 1'b1;
      @(posedge hclk);
      send <= 1'b0;
      ser_rx(rxv);
      chk(rxv, b, "remote to host");
    end
    chk(uart_rts_n, 1'b0, "rts free again");
    disconnect_request_line <= 1'b1;
    poll(link_up_indicator_line, 1'b0, 20);
    chk(radio_close, 1'b1, "close");
    acc_seen = 1'b0;
    offer <= 1'b1;
    for (int n = 0; n < 30; n++) begin
      @(posedge hclk);
      acc_seen = acc_seen | (radio_accept === 1'b1);
    end
    offer <= 1'b0;
    chk(acc_seen, 1'b0, "accept blocked");
    chk(link_up_indicator_line, 1'b0, "stays down");
    ahb(1'b1, OFS_CMD, 32'h1);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[1], 1'b1, "cmd mode");
    b = 8'($urandom);
    ser_tx(b);
    chk(uart_rts_n, 1'b1, "rts held off");
    ahb(1'b0, OFS_RXDATA, 32'h0);
    chk(rd, {24'h0, b}, "command byte");
    b = 8'($urandom);
    ahb(1'b1, OFS_TXDATA, {24'h0, b});
    ser_rx(rxv);
    chk(rxv, b, "command reply");
    ahb(1'b1, OFS_CTRL, 32'h3);
    poll(nv_store, 1'b1, 4);
    chk(nv_data, 3'h3, "nv data");
    chk(general_io_line_oe, drv_mask(1'b1), "dce oe");
    ahb(1'b1, OFS_CMD, 32'h4);
    poll(module_restart, 1'b1, 4);
    chk(radio_page, 1'b0, "page blocked");
    disconnect_request_line <= 1'b0;
    poll(radio_page, 1'b1, 20);
    final_report();
  end
endmodule
